/* design/fsg_frame_sync_generator.sv */
// fsg_frame_sync_generator: frame pacing source toward the back-channel pins
`timescale 1ns/10ps

module fsg_frame_sync_generator
    import fsg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // general purpose pins and back channel
    input wire logic [FSG_PIN_COUNT-1:0] i_gpio,
    output logic [FSG_BC_PINS-1:0] o_backchannel_pin,
    output logic o_frame_pacing_signal
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    fsg_ctl_t sync_control;
    logic [7:0] sync_high_count_upper;
    logic [7:0] sync_high_count_lower;
    logic [7:0] sync_low_count_upper;
    logic [7:0] sync_low_count_lower;
    logic [7:0] backchannel_config;
    logic [7:0] backchannel_pin_route_a;
    logic [7:0] backchannel_pin_route_b;

    function automatic logic fsg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        fsg_hit = (addr == ofs);
    endfunction

    wire logic wr_ctl = i_reg_wr && fsg_hit(i_reg_addr, FSG_OFS_CTL);
    wire logic wr_hu = i_reg_wr && fsg_hit(i_reg_addr, FSG_OFS_HIGH_UP);
    wire logic wr_hl = i_reg_wr && fsg_hit(i_reg_addr, FSG_OFS_HIGH_LO);
    wire logic wr_lu = i_reg_wr && fsg_hit(i_reg_addr, FSG_OFS_LOW_UP);
    wire logic wr_ll = i_reg_wr && fsg_hit(i_reg_addr, FSG_OFS_LOW_LO);
    wire logic wr_bc = i_reg_wr && fsg_hit(i_reg_addr, FSG_OFS_BC_CFG);
    wire logic wr_ra = i_reg_wr && fsg_hit(i_reg_addr, FSG_OFS_ROUTE_A);
    wire logic wr_rb = i_reg_wr && fsg_hit(i_reg_addr, FSG_OFS_ROUTE_B);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync_control <= fsg_ctl_t'(FSG_CTL_RST);
        end
        else if (wr_ctl)
        begin
            sync_control <= fsg_ctl_t'(i_reg_wdata & 8'hf7);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync_high_count_upper <= FSG_COUNT_RST;
            sync_high_count_lower <= FSG_COUNT_RST;
            sync_low_count_upper <= FSG_COUNT_RST;
            sync_low_count_lower <= FSG_COUNT_RST;
        end
        else
        begin
            if (wr_hu)
                sync_high_count_upper <= i_reg_wdata;
            if (wr_hl)
                sync_high_count_lower <= i_reg_wdata;
            if (wr_lu)
                sync_low_count_upper <= i_reg_wdata;
            if (wr_ll)
                sync_low_count_lower <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            backchannel_config <= FSG_BC_CFG_RST;
            backchannel_pin_route_a <= FSG_ROUTE_RST;
            backchannel_pin_route_b <= FSG_ROUTE_RST;
        end
        else
        begin
            if (wr_bc)
                backchannel_config <= i_reg_wdata;
            if (wr_ra)
                backchannel_pin_route_a <= i_reg_wdata;
            if (wr_rb)
                backchannel_pin_route_b <= i_reg_wdata;
        end
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        case (i_reg_addr)
            FSG_OFS_CTL: next_rdata = sync_control;
            FSG_OFS_HIGH_UP: next_rdata = sync_high_count_upper;
            FSG_OFS_HIGH_LO: next_rdata = sync_high_count_lower;
            FSG_OFS_LOW_UP: next_rdata = sync_low_count_upper;
            FSG_OFS_LOW_LO: next_rdata = sync_low_count_lower;
            FSG_OFS_BC_CFG: next_rdata = backchannel_config;
            FSG_OFS_ROUTE_A: next_rdata = backchannel_pin_route_a;
            FSG_OFS_ROUTE_B: next_rdata = backchannel_pin_route_b;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
                o_reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // tick: one back-channel frame
    // ----------------------------------------
    // only port 0 exists here, so every internal source value uses its frame
    // tick port select
    wire logic [2:0] rate_select = backchannel_config[2:0];
    wire logic [11:0] frame_cycles = (rate_select == FSG_RATE_50M) ? FSG_FRAME_CYC_50M :
                                     (rate_select == FSG_RATE_2M5) ? FSG_FRAME_CYC_2M5 :
                                     FSG_FRAME_CYC_10M;
    logic [11:0] tick_count;
    logic tick;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tick_count <= 12'h000;
            tick <= 1'b0;
        end
        else if (tick_count >= frame_cycles - 12'h001)
        begin
            tick_count <= 12'h000;
            tick <= 1'b1;
        end
        else
        begin
            tick_count <= tick_count + 12'h001;
            tick <= 1'b0;
        end
    end

    // ----------------------------------------
    // external input synchroniser
    // ----------------------------------------
    logic [FSG_PIN_COUNT-1:0] gpio_meta;
    logic [FSG_PIN_COUNT-1:0] gpio_sync;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            gpio_meta <= '0;
            gpio_sync <= '0;
        end
        else
        begin
            gpio_meta <= i_gpio;
            gpio_sync <= gpio_meta;
        end
    end

    // ----------------------------------------
    // generator
    // ----------------------------------------
    typedef enum logic [1:0] {FSG_IDLE, FSG_FIRST, FSG_HOLD} fsg_state_t;
    fsg_state_t state;
    logic level;
    logic [15:0] phase_count;
    wire logic [15:0] high_count = {sync_high_count_upper, sync_high_count_lower};
    wire logic [15:0] low_count = {sync_low_count_upper, sync_low_count_lower};
    // duty select: 50/50 reuses the high count for both phases
    wire logic [15:0] phase_len = (sync_control.duty_select || level) ? high_count : low_count;
    wire logic ext_mode = !sync_control.generator_on && sync_control.source_select >= FSG_SRC_EXT_FIRST;
    wire logic ext_level = gpio_sync[sync_control.source_select[2:0]];

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= FSG_IDLE;
            level <= 1'b0;
            phase_count <= 16'h0000;
        end
        else
        begin
            case (state)
                FSG_IDLE:
                begin
                    phase_count <= 16'h0000;
                    if (sync_control.generator_on)
                    begin
                        state <= FSG_FIRST;
                        level <= sync_control.initial_level;
                    end
                    else if (ext_mode)
                    begin
                        // level holds between ticks, so the far side sees a clean copy of the input
                        if (tick)
                            level <= ext_level;
                    end
                    else
                        level <= sync_control.initial_level;
                end
                FSG_FIRST:
                begin
                    phase_count <= 16'h0000;
                    if (!sync_control.generator_on)
                        state <= FSG_IDLE;
                    else if (tick)
                        state <= FSG_HOLD;
                end
                FSG_HOLD:
                begin
                    if (!sync_control.generator_on)
                        state <= FSG_IDLE;
                    // free-running toggle
                    // a count rewritten mid-phase applies from the next tick on;
                    // software that wants clean phases rewrites counts with the generator off
                    else if (tick && phase_count >= phase_len)
                    begin
                        level <= !level;
                        phase_count <= 16'h0000;
                    end
                    else if (tick)
                        phase_count <= phase_count + 16'h0001;
                end
                default:
                    state <= FSG_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // back-channel routing
    // ----------------------------------------
    wire logic [15:0] route_fields = {backchannel_pin_route_b, backchannel_pin_route_a};
    wire logic pacing = (state != FSG_IDLE || ext_mode) ? level : 1'b0;
    genvar gi;
    generate
        for (gi = 0; gi < FSG_BC_PINS; gi = gi + 1)
        begin : g_route
            // pin carries pacing only when routed
            always_ff @(posedge i_clk or posedge i_rst)
            begin
                if (i_rst)
                    o_backchannel_pin[gi] <= 1'b0;
                else
                    o_backchannel_pin[gi] <= (route_fields[gi*4 +: 4] == FSG_ROUTE_PACING) && pacing;
            end
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_frame_pacing_signal <= 1'b0;
        else
            o_frame_pacing_signal <= pacing;
    end
endmodule

/* design/fsg_pkg.sv */
// fsg_pkg: register map, field layout and timing constants of the frame sync generator
package fsg_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] FSG_OFS_CTL = 8'h18;
    localparam logic [7:0] FSG_OFS_HIGH_UP = 8'h19;
    localparam logic [7:0] FSG_OFS_HIGH_LO = 8'h1a;
    localparam logic [7:0] FSG_OFS_LOW_UP = 8'h1b;
    localparam logic [7:0] FSG_OFS_LOW_LO = 8'h1c;
    localparam logic [7:0] FSG_OFS_BC_CFG = 8'h58;
    localparam logic [7:0] FSG_OFS_ROUTE_A = 8'h6e;
    localparam logic [7:0] FSG_OFS_ROUTE_B = 8'h6f;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int FSG_CTL_ON_BIT = 0;
    localparam int FSG_CTL_DUTY_BIT = 1;
    localparam int FSG_CTL_INIT_BIT = 2;
    localparam logic [7:0] FSG_CTL_RST = 8'h00;
    localparam logic [7:0] FSG_COUNT_RST = 8'h00;
    localparam logic [7:0] FSG_BC_CFG_RST = 8'h06;
    localparam logic [7:0] FSG_ROUTE_RST = 8'h00;
    localparam logic [3:0] FSG_ROUTE_PACING = 4'ha;
    localparam logic [3:0] FSG_SRC_EXT_FIRST = 4'h8;
    localparam logic [2:0] FSG_RATE_2M5 = 3'h0;
    localparam logic [2:0] FSG_RATE_10M = 3'h2;
    localparam logic [2:0] FSG_RATE_50M = 3'h6;
    localparam int FSG_PIN_COUNT = 8;
    localparam int FSG_BC_PINS = 4;
    // ----------------------------------------
    // timing: one back-channel frame of 30 bits
    // ----------------------------------------
    localparam int FSG_CLK_NS = 10;
    localparam int FSG_FRAME_BITS = 30;
    localparam int FSG_BIT_NS_50M = 20;
    localparam int FSG_BIT_NS_10M = 100;
    localparam int FSG_BIT_NS_2M5 = 400;
    localparam logic [11:0] FSG_FRAME_CYC_50M = 12'(FSG_FRAME_BITS * FSG_BIT_NS_50M / FSG_CLK_NS);
    localparam logic [11:0] FSG_FRAME_CYC_10M = 12'(FSG_FRAME_BITS * FSG_BIT_NS_10M / FSG_CLK_NS);
    localparam logic [11:0] FSG_FRAME_CYC_2M5 = 12'(FSG_FRAME_BITS * FSG_BIT_NS_2M5 / FSG_CLK_NS);

    typedef struct packed {
        logic [3:0] source_select;
        logic reserved;
        logic initial_level;
        logic duty_select;
        logic generator_on;
    } fsg_ctl_t;
endpackage

/* verif/fsg_chk.sv */
// port checker for the frame sync generator
`timescale 1ns/10ps
module fsg_chk
    import fsg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // pins
    input wire logic [FSG_PIN_COUNT-1:0] i_gpio,
    input wire logic [FSG_BC_PINS-1:0] o_backchannel_pin,
    input wire logic o_frame_pacing_signal
);
    fsg_ctl_t ctl;
    logic [7:0] ra;
    logic [7:0] wl;
    wire unmapped = !(ra inside {[8'h18:8'h1c], 8'h58, 8'h6e, 8'h6f});
    // shadows of the control and high count low byte writes and of the last read address, so outputs can be tied to their cause
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctl <= '0;
            ra <= '0;
            wl <= '0;
        end
        else
        begin
            if (i_reg_wr && i_reg_addr == FSG_OFS_CTL)
                ctl <= fsg_ctl_t'(i_reg_wdata);
            if (i_reg_wr && i_reg_addr == FSG_OFS_HIGH_LO)
                wl <= i_reg_wdata;
            if (i_reg_rd)
                ra <= i_reg_addr;
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_start;
        $rose(ctl.generator_on);
    endsequence
    sequence s_init_held;
        (o_frame_pacing_signal == ctl.initial_level) [*2];
    endsequence
    a_rvalid_after_rd: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read answer missing");
    a_rvalid_needs_rd: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("read answer without request");
    a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
        else $error("read data moved without read");
    a_count_readback: assert property (o_reg_rvalid && ra == FSG_OFS_HIGH_LO |-> o_reg_rdata == wl)
        else $error("high count low byte readback wrong");
    a_ctl_readback: assert property (o_reg_rvalid && ra == FSG_OFS_CTL |-> o_reg_rdata == (ctl & 8'hf7))
        else $error("control readback wrong");
    a_unmapped_zero: assert property (o_reg_rvalid && unmapped |-> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_off_quiet: assert property ((!ctl.generator_on && !ctl.source_select[3]) [*4] |-> !o_frame_pacing_signal)
        else $error("pacing active while off");
    a_start_level: assert property (s_start |-> ##3 s_init_held)
        else $error("start level wrong");
    a_pin_routed: assert property (|o_backchannel_pin |-> o_frame_pacing_signal || $past(o_frame_pacing_signal))
        else $error("pin high without pacing");
endmodule
bind fsg_frame_sync_generator fsg_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_gpio(i_gpio), .o_backchannel_pin(o_backchannel_pin),
    .o_frame_pacing_signal(o_frame_pacing_signal));

/* verif/fsg_remote_model.sv */
// remote serializer model: times every level run seen on one back-channel pin
`timescale 1ns/10ps
module fsg_remote_model (
    input wire logic i_clk,
    input wire logic i_pin
);
    int run_q[$];
    int lvl_q[$];
    int run = 0;
    logic last = 1'b0;
    always @(posedge i_clk)
    begin
        run++;
        if (i_pin !== last)
        begin
            run_q.push_back(run);
            lvl_q.push_back(int'(last));
            run = 0;
            last = i_pin;
        end
    end
endmodule

/* verif/fsg_frame_sync_generator_tb.sv */
// self-checking bench for the frame sync generator
`timescale 1ns/10ps
module fsg_frame_sync_generator_tb;
    import fsg_pkg::*;
    logic i_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, o_reg_rvalid, o_frame_pacing_signal;
    logic [7:0] i_reg_addr = '0, i_reg_wdata = '0, o_reg_rdata;
    logic [FSG_PIN_COUNT-1:0] i_gpio = '0;
    logic [FSG_BC_PINS-1:0] o_backchannel_pin;
    int n_fail = 0, checked = 0;
    int mdl [256];
    logic [7:0] rt [4] = '{8'h06, 8'h02, 8'h00, 8'h03};
    int tk [4] = '{FSG_FRAME_CYC_50M, FSG_FRAME_CYC_10M, FSG_FRAME_CYC_2M5, FSG_FRAME_CYC_10M};
    always #5 i_clk = ~i_clk;
    fsg_frame_sync_generator u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_gpio(i_gpio), .o_backchannel_pin(o_backchannel_pin), .o_frame_pacing_signal(o_frame_pacing_signal));
    fsg_remote_model u_rem (.i_clk(i_clk), .i_pin(o_backchannel_pin[0]));
    function automatic bit mapped(logic [7:0] a);
        return a inside {[8'h18:8'h1c], 8'h58, 8'h6e, 8'h6f};
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
            n_fail++;
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge i_clk);
        #1;
        i_reg_wr = 1;
        i_reg_addr = a;
        i_reg_wdata = d;
        if (mapped(a))
            mdl[a] = (a == FSG_OFS_CTL) ? int'(d & 8'hf7) : int'(d);
        @(posedge i_clk);
        #1;
        i_reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge i_clk);
        #1;
        i_reg_rd = 1;
        i_reg_addr = a;
        @(posedge i_clk);
        #1;
        i_reg_rd = 0;
        chk("rvalid", o_reg_rvalid, 1);
        chk("rdata", o_reg_rdata, mapped(a) ? mdl[a] : 0);
    endtask
    // bounded wait on the partner queue or on pin 0; a bound that runs out ends the run
    task automatic wait_for(int nq, logic v, int lim);
        int n;
        n = 0;
        while ((nq > 0 ? u_rem.run_q.size() < nq : o_backchannel_pin[0] !== v) && n < lim)
        begin
            @(posedge i_clk);
            n++;
        end
        #1;
        if (n >= lim)
        begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic gen(int r, logic [7:0] c);
        logic [15:0] hi, lo;
        hi = 16'($urandom_range(3));
        lo = 16'($urandom_range(3));
        // the bench clock stands for an exact reference, so counts go in unscaled
        wr(FSG_OFS_BC_CFG, rt[r]);
        wr(FSG_OFS_HIGH_UP, hi[15:8]);
        wr(FSG_OFS_HIGH_LO, hi[7:0]);
        wr(FSG_OFS_LOW_UP, lo[15:8]);
        wr(FSG_OFS_LOW_LO, lo[7:0]);
        wr(FSG_OFS_CTL, c);
        repeat (5) @(posedge i_clk);
        #1;
        chk("init", o_backchannel_pin[0], c[2]);
        u_rem.run_q.delete();
        u_rem.lvl_q.delete();
        wait_for(5, 1'b0, 40000);
        // the first run is partial, it began before the queue was cleared
        for (int i = 1; i < 5; i++)
            chk("phase", u_rem.run_q[i], ((u_rem.lvl_q[i] || c[1]) ? hi + 1 : lo + 1) * tk[r]);
        // the level now standing is the inverse of the last finished run
        chk("pin0", o_backchannel_pin[0], !u_rem.lvl_q[4]);
        chk("pin1", o_backchannel_pin[1], !u_rem.lvl_q[4]);
        chk("pin2", o_backchannel_pin[2], !u_rem.lvl_q[4]);
        chk("pin3", o_backchannel_pin[3], 0);
        chk("pacing", o_frame_pacing_signal, !u_rem.lvl_q[4]);
        wr(FSG_OFS_CTL, c & 8'hfe);
        repeat (6) @(posedge i_clk);
        #1;
        chk("stop", o_backchannel_pin[0], 0);
        chk("stop_pacing", o_frame_pacing_signal, 0);
    endtask
    initial
    begin
        void'($urandom(85873));
        foreach (mdl[a]) mdl[a] = 0;
        mdl[FSG_OFS_BC_CFG] = 8'h06;
        repeat (4) @(posedge i_clk);
        #1 i_rst = 0;
        foreach (rt[i]) rd(8'h18 + 8'(i));
        rd(8'h1c);
        rd(FSG_OFS_BC_CFG);
        rd(FSG_OFS_ROUTE_A);
        rd(FSG_OFS_ROUTE_B);
        wr(8'h20, 8'h5a);
        rd(8'h20);
        rd(8'hff);
        for (int a = 8'h18; a <= 8'h1c; a++)
        begin
            wr(8'(a), (a == 8'h18) ? 8'($urandom) & 8'h7e : 8'($urandom));
            rd(8'(a));
        end
        wr(FSG_OFS_ROUTE_A, 8'haa);
        wr(FSG_OFS_ROUTE_B, 8'h0a);
        rd(FSG_OFS_ROUTE_B);
        // rate codes 6, 2, 0 and the unlisted 3, with duty and start level taken from the loop index
        for (int r = 0; r < 4; r++)
            gen(r, {4'h0, 1'b0, r[0], r[1], 1'b1});
        wr(FSG_OFS_BC_CFG, 8'h06);
        // each external source pin must win against the other seven
        for (int k = 0; k < FSG_PIN_COUNT; k++)
        begin
            i_gpio = 8'(1 << k);
            wr(FSG_OFS_CTL, {4'(8 + k), 4'h0});
            wait_for(0, 1'b1, 2 * FSG_FRAME_CYC_50M + 8);
            chk("ext_hi", o_backchannel_pin[0], 1);
            i_gpio = ~8'(1 << k);
            wait_for(0, 1'b0, 2 * FSG_FRAME_CYC_50M + 8);
            chk("ext_lo", o_backchannel_pin[0], 0);
        end
        wrap_up();
    end
endmodule
